//--- anadv_pkg.sv
package anadv_pkg;

  // Management register addresses
  localparam logic [4:0] ADDR_ID2 = 5'h03;
  localparam logic [4:0] ADDR_ADV = 5'h04;

  // Field positions of the model and revision register
  localparam int ID2_OUI_MSB = 15;
  localparam int ID2_OUI_LSB = 10;
  localparam int ID2_MODEL_MSB = 9;
  localparam int ID2_MODEL_LSB = 4;
  localparam int ID2_REV_MSB = 3;
  localparam int ID2_REV_LSB = 0;

  // Field positions of the advertisement register
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ACK_RSV = 14;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_RSV_MSB = 12;
  localparam int ADV_RSV_LSB = 10;
  localparam int ADV_T4 = 9;
  localparam int ADV_ABIL_MSB = 8;
  localparam int ADV_ABIL_LSB = 5;
  localparam int ADV_SEL_MSB = 4;
  localparam int ADV_SEL_LSB = 0;

  // Values after reset
  localparam logic RST_NEXT_PAGE = 1'b0;
  localparam logic RST_ACK_RSV = 1'b0;
  localparam logic [2:0] RST_RSV = 3'h0;
  localparam logic [3:0] RST_ABILITY = 4'hf;
  localparam logic [4:0] RST_SELECTOR = 5'h01;

  // Capability set reported by the status register, bits 15:11
  localparam logic [4:0] STATUS_ABILITY = 5'h0f;

  // Cycles spent after reset before the select pin is trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    ANADV_INIT,
    ANADV_IDLE,
    ANADV_NEGOTIATE
  } anadv_phase_t;

endpackage : anadv_pkg

//--- anadv_sync2.sv
`timescale 1ns/1ps

module anadv_sync2 (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  // Only the second stage is read downstream
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : anadv_sync2

//--- anadv_regs.sv
`timescale 1ns/1ps

// How it works
// RQ1: Model code fixed in identifier bits 9:4
// RQ2: Revision code fixed in identifier bits 3:0
// RQ3: Selector holds 00001, sent as message type
// RQ4: Next-page bit resets zero, advertises when set
// RQ5: Reserved advertisement bits always read zero
// RQ6: Management writes reserved bits with defaults
// RQ7: Protected bits take writes only under override
// RQ8: Remote-fault bit follows local link fault
// RQ9: Ability bit one advertises, zero denies
// RQ10: Four-pair ability bit always zero
// RQ11: Negotiation off: idle, forced speed, duplex
// RQ12: Negotiation on: four abilities, default one
// RQ13: Status capability bits never follow advertisement
// RQ14: Restart sends updated abilities next exchange
// RQ15: Ability defaults from select pin, enable
// RQ16: Code word built from advertisement register
// RQ17: Identifier readable always, writable under override
// RQ18: Advertisement reads return stored fields immediately
module anadv_regs #(
  // Arbitrary neutral identity values
  parameter logic [5:0] OUI_TAIL = 6'h00,
  parameter logic [5:0] MODEL_CODE = 6'h2a,
  parameter logic [3:0] REVISION_CODE = 4'h3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_rd,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic override_protected_write,
  input wire logic autoneg_enable,
  input wire logic autoneg_restart,
  input wire logic speed_select,
  input wire logic duplex_select,
  input wire logic local_link_fault,
  input wire logic hardware_software_select_pin,
  output logic [15:0] link_code_word,
  output logic link_code_word_valid,
  output logic code_word_reload,
  output logic transmit_idle,
  output logic forced_speed_100,
  output logic forced_full_duplex,
  output logic [4:0] status_ability
);

  typedef struct packed {
    anadv_pkg::anadv_phase_t phase;
    logic [1:0] settle_cnt;
    logic next_page;
    logic ack_rsv;
    logic remote_fault;
    logic [2:0] rsv;
    logic [3:0] ability;
    logic [4:0] selector;
    logic [5:0] oui_tail;
    logic [5:0] model;
    logic [3:0] revision;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] code_word;
    logic code_valid;
    logic reload;
    logic idle_tx;
    logic spd_100;
    logic full_dup;
  } anadv_state_t;

  anadv_state_t state_r;
  anadv_state_t state_nxt;
  logic hw_select_sync;

  anadv_sync2 u_hw_select_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(hardware_software_select_pin),
    .sync_out(hw_select_sync)
  );

  // Reserved, acknowledge and four-pair positions are masked to zero
  function automatic logic [15:0] adv_word(input anadv_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[anadv_pkg::ADV_NEXT_PAGE] = s.next_page; // [RQ4]
    w[anadv_pkg::ADV_REMOTE_FAULT] = s.remote_fault; // [RQ8]
    w[anadv_pkg::ADV_T4] = 1'b0; // [RQ10]
    w[anadv_pkg::ADV_ABIL_MSB:anadv_pkg::ADV_ABIL_LSB] = s.ability; // [RQ9]
    w[anadv_pkg::ADV_SEL_MSB:anadv_pkg::ADV_SEL_LSB] = s.selector; // [RQ3]
    return w; // [RQ5]
  endfunction : adv_word

  function automatic logic [15:0] id2_word(input anadv_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[anadv_pkg::ID2_OUI_MSB:anadv_pkg::ID2_OUI_LSB] = s.oui_tail;
    w[anadv_pkg::ID2_MODEL_MSB:anadv_pkg::ID2_MODEL_LSB] = s.model; // [RQ1]
    w[anadv_pkg::ID2_REV_MSB:anadv_pkg::ID2_REV_LSB] = s.revision; // [RQ2]
    return w;
  endfunction : id2_word

  // Ability defaults; in hardware mode with negotiation off only the forced mode shows
  function automatic logic [3:0] ability_default(input logic hw_mode, input logic an_en,
                                                 input logic spd, input logic dup);
    logic [3:0] a;
    a = anadv_pkg::RST_ABILITY;
    if (hw_mode && !an_en) begin
      a = {spd & dup, spd & ~dup, ~spd & dup, ~spd & ~dup};
    end
    return a;
  endfunction : ability_default

  // One decode serves the read and write strobes alike
  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] target);
    return a == target;
  endfunction : addr_hit

  always_comb begin
    logic wr_adv;
    logic wr_id2;
    logic latch_word;
    wr_adv = mgmt_wr && addr_hit(mgmt_addr, anadv_pkg::ADDR_ADV);
    wr_id2 = mgmt_wr && addr_hit(mgmt_addr, anadv_pkg::ADDR_ID2);
    latch_word = 1'b0;
    state_nxt = state_r;
    state_nxt.reload = 1'b0;
    state_nxt.rvalid = mgmt_rd;

    // Read path answers one cycle after the strobe
    if (mgmt_rd && addr_hit(mgmt_addr, anadv_pkg::ADDR_ID2)) begin
      state_nxt.rdata = id2_word(state_r); // [RQ17]
    end else if (mgmt_rd && addr_hit(mgmt_addr, anadv_pkg::ADDR_ADV)) begin
      state_nxt.rdata = adv_word(state_r); // [RQ18]
    end else if (mgmt_rd) begin
      state_nxt.rdata = 16'h0000;
    end

    // Next-page bit is plain read/write
    if (wr_adv) begin
      state_nxt.next_page = mgmt_wdata[anadv_pkg::ADV_NEXT_PAGE]; // [RQ4]
    end

    // Protected fields; management is expected to write defaults here
    if (wr_adv && override_protected_write) begin
      state_nxt.ack_rsv = mgmt_wdata[anadv_pkg::ADV_ACK_RSV]; // [RQ7]
      state_nxt.rsv = mgmt_wdata[anadv_pkg::ADV_RSV_MSB:anadv_pkg::ADV_RSV_LSB]; // [RQ7] [RQ6]
      state_nxt.ability = mgmt_wdata[anadv_pkg::ADV_ABIL_MSB:anadv_pkg::ADV_ABIL_LSB]; // [RQ7]
      state_nxt.selector = mgmt_wdata[anadv_pkg::ADV_SEL_MSB:anadv_pkg::ADV_SEL_LSB]; // [RQ7]
    end
    if (wr_id2 && override_protected_write) begin
      state_nxt.oui_tail = mgmt_wdata[anadv_pkg::ID2_OUI_MSB:anadv_pkg::ID2_OUI_LSB];
      state_nxt.model = mgmt_wdata[anadv_pkg::ID2_MODEL_MSB:anadv_pkg::ID2_MODEL_LSB]; // [RQ17]
      state_nxt.revision = mgmt_wdata[anadv_pkg::ID2_REV_MSB:anadv_pkg::ID2_REV_LSB]; // [RQ17]
    end

    // Hardware owns the fault bit, so a management write cannot mask a live fault
    state_nxt.remote_fault = local_link_fault; // [RQ8]

    unique case (state_r.phase)
      anadv_pkg::ANADV_INIT: begin
        // Wait for the select pin to clear its synchroniser before sampling it
        if (state_r.settle_cnt == anadv_pkg::SETTLE_CYCLES) begin
          state_nxt.ability = ability_default(hw_select_sync, autoneg_enable,
                                              speed_select, duplex_select); // [RQ15] [RQ12]
          if (autoneg_enable) begin
            state_nxt.phase = anadv_pkg::ANADV_NEGOTIATE;
            latch_word = 1'b1;
          end else begin
            state_nxt.phase = anadv_pkg::ANADV_IDLE;
          end
        end else begin
          state_nxt.settle_cnt = state_r.settle_cnt + 2'h1;
        end
      end
      anadv_pkg::ANADV_IDLE: begin
        if (autoneg_enable) begin
          state_nxt.phase = anadv_pkg::ANADV_NEGOTIATE;
          latch_word = 1'b1;
        end
      end
      anadv_pkg::ANADV_NEGOTIATE: begin
        if (!autoneg_enable) begin
          state_nxt.phase = anadv_pkg::ANADV_IDLE; // [RQ11]
        end else if (autoneg_restart) begin
          latch_word = 1'b1; // [RQ14]
        end
      end
    endcase

    // The word is frozen between exchanges so a half-written field never goes out
    if (latch_word) begin
      state_nxt.code_word = adv_word(state_nxt); // [RQ16] [RQ14]
      state_nxt.reload = 1'b1;
    end
    state_nxt.code_valid = (state_nxt.phase == anadv_pkg::ANADV_NEGOTIATE); // [RQ16] [RQ12]
    state_nxt.idle_tx = (state_nxt.phase == anadv_pkg::ANADV_IDLE); // [RQ11]
    state_nxt.spd_100 = speed_select; // [RQ11]
    state_nxt.full_dup = duplex_select; // [RQ11]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r.phase <= anadv_pkg::ANADV_INIT;
      state_r.settle_cnt <= 2'h0;
      state_r.next_page <= anadv_pkg::RST_NEXT_PAGE; // [RQ4]
      state_r.ack_rsv <= anadv_pkg::RST_ACK_RSV;
      state_r.remote_fault <= 1'b0;
      state_r.rsv <= anadv_pkg::RST_RSV;
      state_r.ability <= anadv_pkg::RST_ABILITY; // [RQ12]
      state_r.selector <= anadv_pkg::RST_SELECTOR; // [RQ3]
      state_r.oui_tail <= OUI_TAIL;
      state_r.model <= MODEL_CODE; // [RQ1]
      state_r.revision <= REVISION_CODE; // [RQ2]
      state_r.rdata <= 16'h0000;
      state_r.rvalid <= 1'b0;
      state_r.code_word <= 16'h0000;
      state_r.code_valid <= 1'b0;
      state_r.reload <= 1'b0;
      state_r.idle_tx <= 1'b0;
      state_r.spd_100 <= 1'b0;
      state_r.full_dup <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign mgmt_rdata = state_r.rdata;
  assign mgmt_rvalid = state_r.rvalid;
  assign link_code_word = state_r.code_word;
  assign link_code_word_valid = state_r.code_valid;
  assign code_word_reload = state_r.reload;
  assign transmit_idle = state_r.idle_tx;
  assign forced_speed_100 = state_r.spd_100;
  assign forced_full_duplex = state_r.full_dup;
  // Status capability is a constant, untouched by the advertisement
  assign status_ability = anadv_pkg::STATUS_ABILITY; // [RQ13]

endmodule : anadv_regs

//--- anadv_regs_properties.sv
`timescale 1ns/1ps
module anadv_regs_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire logic local_link_fault,
  input wire logic autoneg_enable,
  input wire logic speed_select,
  input wire logic [15:0] link_code_word,
  input wire logic link_code_word_valid,
  input wire logic transmit_idle,
  input wire logic forced_speed_100,
  input wire logic [4:0] status_ability
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_ID_READ: assert property (
    mgmt_rd && mgmt_addr == 5'h03 |=> mgmt_rvalid && mgmt_rdata[9:0] == 10'h2a3)
    else $error("identifier read wrong");
  AST_ADV_FIXED: assert property (
    mgmt_rd && mgmt_addr == 5'h04 |=> mgmt_rdata[14] == 1'b0 && mgmt_rdata[12:9] == 4'h0
    && mgmt_rdata[4:0] == 5'h01) else $error("fixed advertisement bits wrong");
  AST_FAULT: assert property (
    !$past(srst) && $stable(local_link_fault) && mgmt_rd && mgmt_addr == 5'h04
    |=> mgmt_rdata[13] == $past(local_link_fault)) else $error("fault bit wrong");
  AST_WORD: assert property (
    link_code_word_valid |-> link_code_word[14] == 1'b0 && link_code_word[12:9] == 4'h0
    && link_code_word[4:0] == 5'h01) else $error("code word layout wrong");
  AST_IDLE: assert property (
    link_code_word_valid && !autoneg_enable |=> transmit_idle && !link_code_word_valid)
    else $error("idle not entered");
  AST_FORCED: assert property (
    transmit_idle |-> forced_speed_100 == $past(speed_select)) else $error("forced speed wrong");
  AST_STATUS: assert property (
    status_ability == 5'h0f) else $error("status ability changed");
  AST_RVALID: assert property (
    mgmt_rvalid |-> $past(mgmt_rd)) else $error("read answer without request");
  COV_READ: cover property (mgmt_rvalid);
  COV_NEG: cover property ($rose(link_code_word_valid));
  COV_IDLE: cover property ($rose(transmit_idle));
endmodule : anadv_regs_props

bind anadv_regs anadv_regs_props anadv_regs_props_i (.ref_clk(ref_clk), .srst(srst),
  .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
  .mgmt_rvalid(mgmt_rvalid), .local_link_fault(local_link_fault),
  .autoneg_enable(autoneg_enable), .speed_select(speed_select),
  .link_code_word(link_code_word), .link_code_word_valid(link_code_word_valid),
  .transmit_idle(transmit_idle), .forced_speed_100(forced_speed_100),
  .status_ability(status_ability));

//--- anadv_sta_model.sv
`timescale 1ns/1ps
module anadv_sta_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  output logic [4:0] mgmt_addr = 5'h00,
  output logic mgmt_wr = 1'b0,
  output logic mgmt_rd = 1'b0,
  output logic [15:0] mgmt_wdata = 16'h0000
);
  // One-cycle strobes; idle bus lines toggle so stale values are never trusted
  always @(posedge ref_clk) begin
    mgmt_wr <= go && wr;
    mgmt_rd <= go && !wr;
    mgmt_addr <= go ? addr : ~mgmt_addr;
    // Reserved positions carry their default of zero on every advertisement access
    mgmt_wdata <= go ? ((addr == 5'h04) ? (wdata & 16'ha3ff) : wdata) : ~mgmt_wdata;
  end
endmodule : anadv_sta_model

//--- anadv_regs_test.sv
`timescale 1ns/1ps
module anadv_regs_test;
  typedef struct packed {
    logic ovr; logic [4:0] addr; logic [15:0] wdata; logic [15:0] exp;
  } anadv_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0, wr = 1'b0, ovr = 1'b0, ena = 1'b1, rst_req = 1'b0;
  logic spd = 1'b0, dup = 1'b0, fault = 1'b0, hw = 1'b0;
  logic [4:0] addr = 5'h00, m_addr, stat;
  logic [15:0] wdata = 16'h0000, m_wdata, rdata, lcw;
  logic m_wr, m_rd, rvalid, lcw_v, reload, idle, f100, ffd;
  int err_total = 0;
  int compares = 0;
  anadv_row_t rows [5] = '{
    '{1'b0, 5'h04, 16'h0000, 16'h01e1}, '{1'b0, 5'h04, 16'h8000, 16'h81e1},
    '{1'b1, 5'h04, 16'h0361, 16'h0161}, '{1'b0, 5'h03, 16'hffff, 16'h02a3},
    '{1'b0, 5'h1f, 16'hffff, 16'h0000}};
  anadv_sta_model anadv_sta_model_i (.ref_clk(ref_clk), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .mgmt_addr(m_addr), .mgmt_wr(m_wr), .mgmt_rd(m_rd), .mgmt_wdata(m_wdata));
  anadv_regs anadv_regs_i (.ref_clk(ref_clk), .srst(srst), .mgmt_addr(m_addr), .mgmt_wr(m_wr),
    .mgmt_wdata(m_wdata), .mgmt_rd(m_rd), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
    .override_protected_write(ovr), .autoneg_enable(ena), .autoneg_restart(rst_req),
    .speed_select(spd), .duplex_select(dup), .local_link_fault(fault),
    .hardware_software_select_pin(hw), .link_code_word(lcw), .link_code_word_valid(lcw_v),
    .code_word_reload(reload), .transmit_idle(idle), .forced_speed_100(f100),
    .forced_full_duplex(ffd), .status_ability(stat));
  initial forever #10 ref_clk = ~ref_clk;
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // Reads end as soon as the answer strobe shows; writes just run out the count
  task access(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin go <= 1'b1; wr <= w; addr <= a; wdata <= d; end
    @(posedge ref_clk) go <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      #1;
      if (!w && rvalid === 1'b1) break;
    end
  endtask : access
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(lcw, 16'h01e1, "initial code word");
    foreach (rows[i]) begin
      @(posedge ref_clk) ovr <= rows[i].ovr;
      access(1'b1, rows[i].addr, rows[i].wdata);
      access(1'b0, rows[i].addr, 16'h0000);
      chk(rdata, rows[i].exp, "row read");
    end
    $display("test rows done");
    @(posedge ref_clk) begin ovr <= 1'b0; fault <= 1'b1; end
    repeat (3) @(posedge ref_clk);
    rst_req <= 1'b1;
    @(posedge ref_clk) rst_req <= 1'b0;
    #1;
    chk({15'h0000, reload}, 16'h0001, "reload pulse");
    repeat (2) @(posedge ref_clk);
    #1;
    chk(lcw, 16'h2161, "restart code word");
    chk({15'h0000, reload}, 16'h0000, "reload ends");
    access(1'b0, 5'h04, 16'h0000);
    chk(rdata, 16'h2161, "fault read");
    $display("test restart done");
    @(posedge ref_clk) begin ena <= 1'b0; spd <= 1'b1; dup <= 1'b1; fault <= 1'b0; end
    repeat (3) @(posedge ref_clk);
    #1;
    chk({12'h000, ffd, idle, f100, lcw_v}, 16'h000e, "forced idle");
    @(posedge ref_clk) rst_req <= 1'b1;
    @(posedge ref_clk) rst_req <= 1'b0;
    #1;
    chk({14'h0000, reload, lcw_v}, 16'h0000, "restart ignored in idle");
    $display("test idle done");
    @(posedge ref_clk) begin hw <= 1'b1; dup <= 1'b1; srst <= 1'b1; end
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    access(1'b0, 5'h04, 16'h0000);
    chk(rdata, 16'h0101, "hardware mode defaults");
    @(posedge ref_clk) ena <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(lcw, 16'h0101, "enable code word");
    chk({14'h0000, reload, lcw_v}, 16'h0003, "enable reload");
    $display("test reset done");
    summarize();
  end
  // The sequence needs well under 1000 cycles
  initial begin
    #20us;
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule : anadv_regs_test
